// *** rgbs_deglitch.sv ***
`timescale 1ns/1ps
module rgbs_deglitch
  import rgbs_pkg::*;
#(
  parameter int CYCLES = DEGLITCH_CYCLES
)
(
  // Clock and reset
  input  wire logic  ref_clk,
  input  wire logic  rst,
  // Raw select pins
  input  wire logic [1:0] sel_in,
  // Filtered select
  rgbs_sel_if.src    sel
);
  localparam int CW = $clog2(CYCLES + 1);

  initial
  begin
    if (CYCLES < 1)
      $error("rgbs_deglitch: CYCLES must be at least 1");
  end

  logic [1:0]    stable_r;
  logic [1:0]    change_r;
  logic [CW-1:0] cnt_r [2];

  // Each pin filtered on its own; a pulse shorter than the window is dropped
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_bit
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          stable_r[g] <= 1'b0;
          change_r[g] <= 1'b0;
          cnt_r[g]    <= '0;
        end
        else if (sel_in[g] == stable_r[g])
        begin
          cnt_r[g]    <= '0;
          change_r[g] <= 1'b0;
        end
        else if (cnt_r[g] == CW'(CYCLES - 1))
        begin
          stable_r[g] <= sel_in[g];
          cnt_r[g]    <= '0;
          change_r[g] <= 1'b1;
        end
        else
        begin
          cnt_r[g]    <= cnt_r[g] + CW'(1);
          change_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign sel.sel_stable = stable_r;
  assign sel.sel_change = |change_r;

endmodule : rgbs_deglitch

// *** rgbs_disp_model.sv ***
`timescale 1ns/1ps
module rgbs_disp_model
  import rgbs_pkg::*;
(
  // Clock and control
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [7:0] hold,
  // Color select
  output logic      [1:0] color_sel
);
  logic [7:0] cnt_r;
  // Hold sets a prompt or slow pace
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_r     <= 8'h00;
      color_sel <= SEL_A;
    end
    else if (run && cnt_r == hold)
    begin
      cnt_r     <= 8'h00;
      color_sel <= (color_sel == SEL_C) ? SEL_A : color_sel + 2'h1;
    end
    else if (run)
      cnt_r <= cnt_r + 8'h01;
  end
endmodule : rgbs_disp_model

// *** rgbs_pkg.sv ***
package rgbs_pkg;

  // Register offsets, byte addresses on the plain port
  localparam logic [7:0] ADDR_CODE_A    = 8'h01;
  localparam logic [7:0] ADDR_CODE_A_HI = 8'h02;
  localparam logic [7:0] ADDR_CODE_B    = 8'h03;
  localparam logic [7:0] ADDR_CODE_B_HI = 8'h04;
  localparam logic [7:0] ADDR_CODE_C    = 8'h05;
  localparam logic [7:0] ADDR_CODE_C_HI = 8'h06;
  localparam logic [7:0] ADDR_CTRL      = 8'h07;
  localparam logic [7:0] ADDR_STATE     = 8'h08;
  localparam logic [7:0] ADDR_DEAD_TIME = 8'h0B;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h0C;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h0D;

  // Reset values
  localparam logic [7:0] DEAD_TIME_RST  = 8'h10;
  localparam logic [7:0] INT_MASK_RST   = 8'h00;
  localparam logic [9:0] CODE_RST       = 10'h000;

  // Control register fields
  localparam int CTRL_RAILS_OK_BIT = 0;

  // Interrupt status fields
  localparam int INT_FAULT_BIT   = 0;
  localparam int INT_SEL_CHG_BIT = 1;
  localparam int INT_BBM_END_BIT = 2;
  localparam int INT_BITS        = 3;

  // Deglitch time
  localparam int CLK_MHZ          = 100;
  localparam int DEGLITCH_NS      = 300;
  localparam int DEGLITCH_CYCLES  = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;

  // Color select codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_A    = 2'h1;
  localparam logic [1:0] SEL_B    = 2'h2;
  localparam logic [1:0] SEL_C    = 2'h3;

  typedef enum logic [1:0] {ST_OFF, ST_BREAK, ST_RUN} rgbs_state_e;

endpackage : rgbs_pkg

// *** rgbs_sel_if.sv ***
`timescale 1ns/1ps
interface rgbs_sel_if;
  logic [1:0] sel_stable;
  logic       sel_change;
  modport src (output sel_stable, output sel_change);
  modport dst (input sel_stable, input sel_change);
endinterface : rgbs_sel_if

// *** rgbs_strobe.sv ***
`timescale 1ns/1ps
module rgbs_strobe
  import rgbs_pkg::*;
#(
  parameter int CODE_W = 10
)
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Color select and power
  input  wire logic [1:0]        color_sel,
  input  wire logic              system_power_on,
  input  wire logic              rails_ready,
  input  wire logic              fault_in,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Switches and current
  output logic                   switch_a,
  output logic                   switch_b,
  output logic                   switch_c,
  output logic      [CODE_W-1:0] dac_code,
  output logic                   dac_active,
  // Interrupt
  output logic                   irq_n_out
);

  initial
  begin
    if (CODE_W != 10)
      $error("rgbs_strobe: CODE_W must be 10");
  end

  rgbs_sel_if sel ();

  rgbs_deglitch #(
    .CYCLES (DEGLITCH_CYCLES)
  ) u_deglitch (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sel_in  (color_sel),
    .sel     (sel)
  );

  logic [CODE_W-1:0] code_a_r;
  logic [CODE_W-1:0] code_b_r;
  logic [CODE_W-1:0] code_c_r;
  logic [7:0]        dead_time_r;
  logic [7:0]        int_mask_r;
  logic [INT_BITS-1:0] int_stat_r;
  logic              rails_sw_r;
  logic [7:0]        rdata_r;
  rgbs_state_e       state_r;
  logic [7:0]        dt_cnt_r;
  logic [2:0]        sw_r;
  logic [1:0]        target_r;
  logic [CODE_W-1:0] dac_r;
  logic              dac_act_r;
  logic              fault_d_r;
  logic              enable;
  logic [2:0]        want;
  logic [2:0]        keep;
  logic [INT_BITS-1:0] int_set;
  logic              bbm_done;

  // Decoder runs only with rails up and power on
  assign enable = system_power_on & rails_ready & rails_sw_r;

  // One-hot decode of a select code
  function automatic logic [2:0] rgbs_decode(input logic [1:0] code);
    logic [2:0] v;
    v = 3'h0;
    case (code)
      SEL_A:   v = 3'h1;
      SEL_B:   v = 3'h2;
      SEL_C:   v = 3'h4;
      default: v = 3'h0;
    endcase
    return v;
  endfunction : rgbs_decode

  assign want = rgbs_decode(sel.sel_stable);
  assign keep = sw_r & rgbs_decode(target_r);

  // Register writes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      code_a_r    <= CODE_RST;
      code_b_r    <= CODE_RST;
      code_c_r    <= CODE_RST;
      dead_time_r <= DEAD_TIME_RST;
      int_mask_r  <= INT_MASK_RST;
      rails_sw_r  <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_CODE_A:    code_a_r[7:0] <= reg_wdata;
        ADDR_CODE_A_HI: code_a_r[9:8] <= reg_wdata[1:0];
        ADDR_CODE_B:    code_b_r[7:0] <= reg_wdata;
        ADDR_CODE_B_HI: code_b_r[9:8] <= reg_wdata[1:0];
        ADDR_CODE_C:    code_c_r[7:0] <= reg_wdata;
        ADDR_CODE_C_HI: code_c_r[9:8] <= reg_wdata[1:0];
        ADDR_CTRL:      rails_sw_r <= reg_wdata[CTRL_RAILS_OK_BIT];
        ADDR_DEAD_TIME: dead_time_r <= reg_wdata;
        ADDR_INT_MASK:  int_mask_r <= reg_wdata;
        default:        ;
      endcase
    end
  end

  // Break-before-make sequencer
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r  <= ST_OFF;
      sw_r     <= 3'h0;
      target_r <= SEL_NONE;
      dt_cnt_r <= 8'h00;
    end
    else if (!enable)
    begin
      state_r  <= ST_OFF;
      sw_r     <= 3'h0;
      target_r <= SEL_NONE;
      dt_cnt_r <= 8'h00;
    end
    else
    begin
      case (state_r)
        ST_OFF, ST_RUN:
        begin
          if (want != sw_r)
          begin
            target_r <= sel.sel_stable;
            sw_r     <= sw_r & want;
            dt_cnt_r <= 8'h00;
            state_r  <= ST_BREAK;
          end
        end
        ST_BREAK:
        begin
          if (sel.sel_stable != target_r)
          begin
            // Restart keeps only switches common to the new selection
            target_r <= sel.sel_stable;
            sw_r     <= keep & want;
            dt_cnt_r <= 8'h00;
          end
          else if (dt_cnt_r >= dead_time_r)
          begin
            sw_r    <= want;
            state_r <= ST_RUN;
          end
          else
            dt_cnt_r <= dt_cnt_r + 8'h01;
        end
        default: state_r <= ST_OFF;
      endcase
    end
  end

  assign bbm_done = (state_r == ST_BREAK) && (sel.sel_stable == target_r) && (dt_cnt_r >= dead_time_r) && enable;

  // Current code follows closed switch only
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dac_r     <= CODE_RST;
      dac_act_r <= 1'b0;
    end
    else
    begin
      case (sw_r)
        3'h1:
        begin
          dac_r     <= code_a_r;
          dac_act_r <= 1'b1;
        end
        3'h2:
        begin
          dac_r     <= code_b_r;
          dac_act_r <= 1'b1;
        end
        3'h4:
        begin
          dac_r     <= code_c_r;
          dac_act_r <= 1'b1;
        end
        default:
        begin
          dac_r     <= CODE_RST;
          dac_act_r <= 1'b0;
        end
      endcase
    end
  end

  // Sticky events; set wins over write-one-clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      fault_d_r <= 1'b0;
    else
      fault_d_r <= fault_in;
  end

  assign int_set[INT_FAULT_BIT]   = fault_in & ~fault_d_r;
  assign int_set[INT_SEL_CHG_BIT] = sel.sel_change;
  assign int_set[INT_BBM_END_BIT] = bbm_done;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      int_stat_r <= '0;
    else if (reg_wr && reg_addr == ADDR_INT_STAT)
      int_stat_r <= (int_stat_r & ~reg_wdata[INT_BITS-1:0]) | int_set;
    else
      int_stat_r <= int_stat_r | int_set;
  end

  // Masked bits never pull the line low; mask bit one means masked
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irq_n_out <= 1'b1;
    else
      irq_n_out <= ~|(int_stat_r & ~int_mask_r[INT_BITS-1:0]);
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CODE_A:    rdata_r <= code_a_r[7:0];
        ADDR_CODE_A_HI: rdata_r <= {6'h00, code_a_r[9:8]};
        ADDR_CODE_B:    rdata_r <= code_b_r[7:0];
        ADDR_CODE_B_HI: rdata_r <= {6'h00, code_b_r[9:8]};
        ADDR_CODE_C:    rdata_r <= code_c_r[7:0];
        ADDR_CODE_C_HI: rdata_r <= {6'h00, code_c_r[9:8]};
        ADDR_CTRL:      rdata_r <= {7'h00, rails_sw_r};
        ADDR_STATE:     rdata_r <= {1'b0, enable, target_r, sel.sel_stable == target_r, sw_r};
        ADDR_DEAD_TIME: rdata_r <= dead_time_r;
        ADDR_INT_STAT:  rdata_r <= {5'h00, int_stat_r};
        ADDR_INT_MASK:  rdata_r <= int_mask_r;
        default:        rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  assign reg_rdata  = rdata_r;
  assign switch_a   = sw_r[0];
  assign switch_b   = sw_r[1];
  assign switch_c   = sw_r[2];
  assign dac_code   = dac_r;
  assign dac_active = dac_act_r;

endmodule : rgbs_strobe

// *** rgbs_strobe_monitor.sv ***
`timescale 1ns/1ps
module rgbs_strobe_monitor
  import rgbs_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Inputs
  input wire logic       system_power_on,
  input wire logic       rails_ready,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  // Outputs
  input wire logic       switch_a,
  input wire logic       switch_b,
  input wire logic       switch_c,
  input wire logic       dac_active,
  input wire logic       irq_n_out
);
  logic [2:0] sw;
  logic [8:0] off_cnt_r;
  logic [7:0] dt_r;
  logic [2:0] mask_r;
  logic       mask_all;
  assign sw       = {switch_c, switch_b, switch_a};
  assign mask_all = &mask_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Open run length, saturates well above the longest dead time
  always_ff @(posedge ref_clk)
  begin
    if (rst || sw != 3'h0)
      off_cnt_r <= 9'h000;
    else if (off_cnt_r != 9'h1FF)
      off_cnt_r <= off_cnt_r + 9'h001;
  end
  // Register shadows
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dt_r   <= DEAD_TIME_RST;
      mask_r <= INT_MASK_RST[2:0];
    end
    else if (reg_wr && reg_addr == ADDR_DEAD_TIME)
      dt_r <= reg_wdata;
    else if (reg_wr && reg_addr == ADDR_INT_MASK)
      mask_r <= reg_wdata[2:0];
  end
  a_switch_onehot: assert property ($onehot0(sw))
    else $error("two switches closed");
  a_off_when_down: assert property
    (!(system_power_on && rails_ready) ##1 !(system_power_on && rails_ready) |-> sw == 3'h0)
    else $error("switch closed while rails down");
  a_break_first: assert property ((sw & ~$past(sw)) != 3'h0 |-> $past(sw) == 3'h0)
    else $error("switch made before break");
  a_dead_time_kept: assert property
    ((sw & ~$past(sw)) != 3'h0 |-> off_cnt_r >= {1'b0, dt_r} + 9'h001)
    else $error("dead time too short");
  a_dac_source: assert property (dac_active |-> $past(sw) != 3'h0)
    else $error("dac active with no switch");
  a_dac_release: assert property (sw == 3'h0 |=> !dac_active)
    else $error("dac still active");
  // Status clears at the write edge, the output follows one edge later
  a_irq_clear: assert property ($rose(irq_n_out) |-> $past(reg_wr, 2) &&
    ($past(reg_addr, 2) == ADDR_INT_STAT || $past(reg_addr, 2) == ADDR_INT_MASK))
    else $error("interrupt released unserviced");
  a_irq_masked: assert property (mask_all && $past(mask_all, 2) |-> irq_n_out)
    else $error("masked interrupt asserted");
endmodule : rgbs_strobe_monitor
bind rgbs_strobe rgbs_strobe_monitor mon_u (.ref_clk(ref_clk), .rst(rst), .system_power_on(system_power_on),
  .rails_ready(rails_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .switch_a(switch_a),
  .switch_b(switch_b), .switch_c(switch_c), .dac_active(dac_active), .irq_n_out(irq_n_out));

// *** rgbs_strobe_tb_top.sv ***
`timescale 1ns/1ps
module rgbs_strobe_tb_top import rgbs_pkg::*;;
  logic        ref_clk, rst, pwr, rails, fault, wr, rd, run, rd_d, due;
  logic        sw_a, sw_b, sw_c, dac_act, irq_n;
  logic [1:0]  mdl_sel, tb_sel, sel;
  logic [2:0]  sw, prev;
  logic [7:0]  addr, wdata, rdata, dt;
  logic [9:0]  dac, due_code;
  logic [9:0]  code [3];
  logic [12:0] note;
  logic [7:0]  rd_q [$];
  logic [12:0] cl_q [$];
  int          error_cnt, checks;
  assign sel = run ? mdl_sel : tb_sel;
  assign sw  = {sw_c, sw_b, sw_a};
  rgbs_strobe dut_u (.ref_clk(ref_clk), .rst(rst), .color_sel(sel), .system_power_on(pwr), .rails_ready(rails),
    .fault_in(fault), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .switch_a(sw_a), .switch_b(sw_b), .switch_c(sw_c), .dac_code(dac), .dac_active(dac_act), .irq_n_out(irq_n));
  rgbs_disp_model model_u (.ref_clk(ref_clk), .rst(rst), .run(run), .hold(8'h50), .color_sel(mdl_sel));
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    rd   <= 1'b1;
    addr <= a;
    rd_q.push_back(exp);
    @(posedge ref_clk);
    rd   <= 1'b0;
  endtask : rd_reg
  task automatic drain();
    int n;
    n = 0;
    while ((cl_q.size() != 0 || due) && n < 3000)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 3000)
    begin
      error_cnt++;
      give_verdict();
    end
  endtask : drain
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #300000;
    error_cnt++;
    give_verdict();
  end
  always @(posedge ref_clk)
    rd_d <= rd;
  // Results are judged at the falling edge, after every update has landed
  always @(negedge ref_clk)
  begin
    if (rd_d)
      chk(13'(rdata), 13'(rd_q.pop_front()));
    if (due)
      chk(13'(dac), 13'(due_code));
    due = 1'b0;
    if ((sw & ~prev) != 3'h0)
    begin
      note     = cl_q.pop_front();
      chk(13'(sw), 13'(note[12:10]));
      due      = 1'b1;
      due_code = note[9:0];
    end
    prev = sw;
  end
  initial
  begin
    {pwr, rails, fault, wr, rd, run, rd_d, due} = 8'h00;
    {addr, wdata, prev} = 19'h00000;
    rst    = 1'b1;
    tb_sel = SEL_A;
    void'($urandom(32'h7C55));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(ADDR_DEAD_TIME, DEAD_TIME_RST);
    rd_reg(ADDR_INT_MASK, INT_MASK_RST);
    rd_reg(8'h20, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      code[i] = 10'($urandom);
      wr_reg(ADDR_CODE_A + 8'(2 * i), code[i][7:0]);
      wr_reg(ADDR_CODE_A_HI + 8'(2 * i), {6'h00, code[i][9:8]});
      rd_reg(ADDR_CODE_A + 8'(2 * i), code[i][7:0]);
    end
    // Short dead times, zero included
    dt = 8'($urandom % 4);
    wr_reg(ADDR_DEAD_TIME, dt);
    wr_reg(ADDR_CTRL, 8'h01);
    cl_q = '{{3'h1, code[0]}, {3'h2, code[1]}, {3'h4, code[2]}, {3'h1, code[0]}};
    pwr   <= 1'b1;
    rails <= 1'b1;
    run   <= 1'b1;
    drain();
    run <= 1'b0;
    // A 29 cycle glitch is one short of acceptance
    tb_sel <= SEL_B;
    repeat (29) @(posedge ref_clk);
    tb_sel <= SEL_A;
    repeat (40) @(posedge ref_clk);
    #1 chk(13'(sw), 13'h1);
    tb_sel <= SEL_NONE;
    repeat (45) @(posedge ref_clk);
    #1 chk(13'({dac_act, sw}), 13'h0);
    wr_reg(ADDR_INT_MASK, 8'h07);
    wr_reg(ADDR_INT_STAT, 8'h07);
    fault <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk(13'(irq_n), 13'h1);
    rd_reg(ADDR_INT_STAT, 8'h01);
    wr_reg(ADDR_INT_MASK, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk(13'(irq_n), 13'h0);
    wr_reg(ADDR_INT_STAT, 8'h01);
    // Output is registered behind the status bit
    @(posedge ref_clk);
    #1 chk(13'(irq_n), 13'h1);
    cl_q.push_back({3'h4, code[2]});
    tb_sel <= SEL_C;
    drain();
    pwr <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk(13'(sw), 13'h0);
    give_verdict();
  end
endmodule : rgbs_strobe_tb_top
